// >>> hdl/gte_consts.vh
// Constants for the general timer with event select
// Notes on behaviour
// - Free-run wraps at max or min value
// - Periodic mode restarts from reload value
// - Count value readable at any time
// - Timer starts on control register write
// - Interrupt at zero down or full up
// - Any write to clear register clears irq_vec_out unless expiry comes in the same cycle
// - Expiry raises interrupt chosen by event field
// - Codes 0 to 17 map interrupts 2 to 19
// - Sub-second bits 6:0 count 0 to 127
// - Hours 31:24, minutes 21:16, seconds 13:8
// - Time layout on reload and count registers
// - Control bit picks periodic or free-run
// - Control bit picks up or down count
// - Selected event copies counter to capture
`ifndef GTE_CONSTS_VH
`define GTE_CONSTS_VH
`define GTE_A_RELOAD   4'h0
`define GTE_A_COUNT    4'h1
`define GTE_A_CTRL     4'h2
`define GTE_A_CLR      4'h3
`define GTE_A_CAPTURE  4'h4
`define GTE_A_STATUS   4'h5
`define GTE_A_MASK     4'h6
`define GTE_A_EVSRC    4'h7
`define GTE_B_PERIODIC 6
`define GTE_B_ENABLE   7
`define GTE_B_UP       8
`define GTE_B_CAPEN    17
`define GTE_ES_HI      16
`define GTE_ES_LO      12
`define GTE_FMT_HI     5
`define GTE_FMT_LO     4
`define GTE_PRE_HI     3
`define GTE_PRE_LO     0
`define GTE_CTRL_MASK  32'h0003f1ff
`define GTE_FMT_HMS    2'h3
`define GTE_PRE_16     4'h4
`define GTE_PRE_256    4'h8
`define GTE_PRE_32K    4'hf
`define GTE_DIV_1      16'h0000
`define GTE_DIV_16     16'h000f
`define GTE_DIV_256    16'h00ff
`define GTE_DIV_32K    16'h7fff
`define GTE_ES_MAX     5'h11
`define GTE_IRQ_BASE   5'h02
`define GTE_SUB_MAX    7'h7f
`define GTE_SM_MAX     6'h3b
`define GTE_HR_MAX     8'hff
`define GTE_ST_EXPIRY  0
`define GTE_ST_CAPTURE 1
`endif

// >>> hdl/gte_prescale.v
// Prescale divider giving a one-cycle tick enable
`timescale 1ns/1ps
`include "gte_consts.vh"
module gte_prescale (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // Control
  input  wire        run_in,
  input  wire        src_tick_in,
  input  wire [3:0]  sel_in,
  // Tick
  output reg         tick_out
);
  reg [15:0] cnt_r;
  reg [15:0] lim;
  always @* begin
    case (sel_in)
      `GTE_PRE_16:  lim = `GTE_DIV_16;
      `GTE_PRE_256: lim = `GTE_DIV_256;
      `GTE_PRE_32K: lim = `GTE_DIV_32K;
      default:      lim = `GTE_DIV_1;
    endcase
  end
  always @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      cnt_r    <= 16'h0000;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (src_tick_in) begin
        if (cnt_r >= lim) begin
          cnt_r    <= 16'h0000;
          tick_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end
endmodule

// >>> hdl/gte_timer.v
// General timer with event select, Wishbone slave and interrupt
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "gte_consts.vh"
module gte_timer (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // Wishbone slave
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [5:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  // Timer clock source pin and event sources
  input  wire        src_clk_in,
  input  wire [17:0] event_in,
  // Interrupt outputs
  output reg  [19:0] irq_vec_out,
  output reg         irq_out
);
  reg [31:0] reload_value_r;
  reg [31:0] count_value_r;
  reg [31:0] timer_control_r;
  reg [31:0] capture_r;
  reg [1:0]  status_r;
  reg [1:0]  mask_r;
  reg        pend_r;
  reg [2:0]  src_sync_r;
  reg [17:0] ev_s1a_r;
  reg [17:0] ev_s2_r;
  reg [17:0] ev_prev_r;
  wire       tick;
  wire       src_tick;
  wire [4:0] es;
  wire       up;
  wire       hms;
  wire       acc;
  wire       wr;
  wire       rd;
  wire       ev_hit;
  wire       at_end;
  reg [31:0] nxt_val;
  reg [31:0] rd_nxt;

  // Byte-lane merge for writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (s[i])
          merge[i*8 +: 8] = d[i*8 +: 8];
    end
  endfunction

  // Time-of-day step with carries
  function [31:0] hms_step;
    input [31:0] v;
    input        dir_up;
    reg   [7:0]  h;
    reg   [5:0]  m;
    reg   [5:0]  s;
    reg   [6:0]  f;
    begin
      h = v[31:24];
      m = v[21:16];
      s = v[13:8];
      f = v[6:0];
      if (dir_up) begin
        if (f != `GTE_SUB_MAX) f = f + 7'h01;
        else begin
          f = 7'h00;
          if (s != `GTE_SM_MAX) s = s + 6'h01;
          else begin
            s = 6'h00;
            if (m != `GTE_SM_MAX) m = m + 6'h01;
            else begin
              m = 6'h00;
              h = h + 8'h01;
            end
          end
        end
      end else begin
        if (f != 7'h00) f = f - 7'h01;
        else begin
          f = `GTE_SUB_MAX;
          if (s != 6'h00) s = s - 6'h01;
          else begin
            s = `GTE_SM_MAX;
            if (m != 6'h00) m = m - 6'h01;
            else begin
              m = `GTE_SM_MAX;
              h = h - 8'h01;
            end
          end
        end
      end
      hms_step = {h, 2'b00, m, 2'b00, s, 1'b0, f};
    end
  endfunction

  // Time-of-day terminal and start values
  function [31:0] hms_full;
    input dummy;
    begin
      hms_full = {`GTE_HR_MAX, 2'b00, `GTE_SM_MAX, 2'b00, `GTE_SM_MAX, 1'b0, `GTE_SUB_MAX};
    end
  endfunction

  assign es  = timer_control_r[`GTE_ES_HI:`GTE_ES_LO];
  assign up  = timer_control_r[`GTE_B_UP];
  assign hms = (timer_control_r[`GTE_FMT_HI:`GTE_FMT_LO] == `GTE_FMT_HMS);
  assign acc = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr  = acc && wb_we_in;
  assign rd  = acc && !wb_we_in;

  // Source pin edge as a tick enable; software picks the 32 kHz source for time format
  assign src_tick = src_sync_r[1] && !src_sync_r[2];

  gte_prescale u_pre (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .run_in      (timer_control_r[`GTE_B_ENABLE]),
    .src_tick_in (src_tick),
    .sel_in      (timer_control_r[`GTE_PRE_HI:`GTE_PRE_LO]),
    .tick_out    (tick)
  );

  assign at_end = hms ? (up ? (count_value_r == hms_full(1'b0)) : (count_value_r == 32'h0))
                      : (up ? (count_value_r == 32'hffffffff) : (count_value_r == 32'h0));

  // Next counter value
  always @* begin
    if (at_end) begin
      if (timer_control_r[`GTE_B_PERIODIC])
        nxt_val = reload_value_r;
      else if (up)
        nxt_val = 32'h0;
      else
        nxt_val = hms ? hms_full(1'b0) : 32'hffffffff;
    end else if (hms)
      nxt_val = hms_step(count_value_r, up);
    else
      nxt_val = up ? count_value_r + 32'h1 : count_value_r - 32'h1;
  end

  // Selected event rising edge; codes above range pick nothing
  assign ev_hit = (es <= `GTE_ES_MAX) && ev_s2_r[es] && !ev_prev_r[es];

  always @(posedge clk_in) begin
    if (rst_in) begin
      src_sync_r <= 3'h0;
      ev_s1a_r   <= 18'h0;
      ev_s2_r    <= 18'h0;
      ev_prev_r  <= 18'h0;
    end else begin
      src_sync_r <= {src_sync_r[1:0], src_clk_in};
      ev_s1a_r   <= event_in;
      ev_s2_r    <= ev_s1a_r;
      ev_prev_r  <= ev_s2_r;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      reload_value_r  <= 32'h0;
      count_value_r   <= 32'h0;
      timer_control_r <= 32'h0;
      capture_r       <= 32'h0;
      pend_r          <= 1'b0;
    end else begin
      if (wr && wb_adr_in[5:2] == `GTE_A_RELOAD)
        reload_value_r <= merge(reload_value_r, wb_dat_in, wb_sel_in);
      if (wr && wb_adr_in[5:2] == `GTE_A_CTRL) begin
        timer_control_r <= merge(timer_control_r, wb_dat_in, wb_sel_in) & `GTE_CTRL_MASK;
        count_value_r   <= reload_value_r;
      end else if (tick)
        count_value_r <= nxt_val;
      if (timer_control_r[`GTE_B_CAPEN] && ev_hit)
        capture_r <= count_value_r;
      // Expiry wins over a clear in the same cycle
      if (tick && at_end)
        pend_r <= 1'b1;
      else if (wr && wb_adr_in[5:2] == `GTE_A_CLR)
        pend_r <= 1'b0;
    end
  end

  // Sticky status: bit 0 expiry, bit 1 capture; read clears, set wins
  always @(posedge clk_in) begin
    if (rst_in) begin
      status_r <= 2'h0;
      mask_r   <= 2'h0;
    end else begin
      if (wr && wb_adr_in[5:2] == `GTE_A_MASK && wb_sel_in[0])
        mask_r <= wb_dat_in[1:0];
      status_r <= ((rd && wb_adr_in[5:2] == `GTE_A_STATUS) ? 2'h0 : status_r)
                | {timer_control_r[`GTE_B_CAPEN] && ev_hit, tick && at_end};
    end
  end

  always @* begin
    case (wb_adr_in[5:2])
      `GTE_A_RELOAD:  rd_nxt = reload_value_r;
      `GTE_A_COUNT:   rd_nxt = count_value_r;
      `GTE_A_CTRL:    rd_nxt = timer_control_r;
      `GTE_A_CAPTURE: rd_nxt = capture_r;
      `GTE_A_STATUS:  rd_nxt = {30'h0, status_r};
      `GTE_A_MASK:    rd_nxt = {30'h0, mask_r};
      `GTE_A_EVSRC:   rd_nxt = {27'h0, es + `GTE_IRQ_BASE};
      default:        rd_nxt = 32'h0;
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      wb_ack_out  <= 1'b0;
      wb_dat_out  <= 32'h0;
      irq_vec_out <= 20'h0;
      irq_out     <= 1'b0;
    end else begin
      wb_ack_out  <= acc;
      wb_dat_out  <= rd ? rd_nxt : 32'h0;
      irq_out     <= |(status_r & mask_r);
      irq_vec_out <= 20'h0;
      // Pending expiry drives the interrupt line picked by the event field
      if (pend_r && es <= `GTE_ES_MAX)
        irq_vec_out[es + `GTE_IRQ_BASE] <= 1'b1;
    end
  end
endmodule

// >>> verification/gte_timer_chk.sv
// Port checker for the general timer
`timescale 1ns/1ps
module gte_timer_chk (
  input wire        clk_in,
  input wire        rst_in,
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_we_in,
  input wire [5:0]  wb_adr_in,
  input wire [31:0] wb_dat_out,
  input wire        wb_ack_out,
  input wire [19:0] irq_vec_out,
  input wire        irq_out
);
  reg  started_r;
  wire req;
  assign req = wb_cyc_in & wb_stb_in;
  // Nothing may fire before software writes control
  always @(posedge clk_in)
    if (rst_in)
      started_r <= 1'b0;
    else if (req & wb_we_in & wb_ack_out & (wb_adr_in[5:2] == 4'h2))
      started_r <= 1'b1;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_ack_next; req & !wb_ack_out |=> wb_ack_out; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_out |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_wr_zero; wb_ack_out & wb_we_in |-> wb_dat_out == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write data out");
  property p_unmap; wb_ack_out & !wb_we_in & wb_adr_in[5] |-> wb_dat_out == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_onehot; $onehot0(irq_vec_out); endproperty
  a_onehot: assert property (p_onehot) else $error("two lines");
  property p_low_bits; irq_vec_out[1:0] == 2'h0; endproperty
  a_low_bits: assert property (p_low_bits) else $error("low line set");
  property p_no_start; !started_r |-> irq_vec_out == 20'h0 && !irq_out; endproperty
  a_no_start: assert property (p_no_start) else $error("irq unstarted");
endmodule
bind gte_timer gte_timer_chk u_gte_timer_chk (.clk_in(clk_in), .rst_in(rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .irq_vec_out(irq_vec_out),
  .irq_out(irq_out));

// >>> verification/gte_timer_tb_top.sv
// Self-checking bench for the general timer
`timescale 1ns/1ps
module gte_timer_tb_top;
  reg         clk_in = 1'b0;
  reg         rst_in = 1'b1;
  reg         cyc    = 1'b0;
  reg         we     = 1'b0;
  reg  [5:0]  adr    = 6'h0;
  reg  [31:0] wd     = 32'h0;
  reg         src    = 1'b0;
  reg  [17:0] ev     = 18'h0;
  wire [31:0] rdat;
  wire        ack;
  wire [19:0] ivec;
  wire        irq;
  integer     error_cnt = 0;
  integer     checks    = 0;
  integer     code;
  reg  [31:0] rd;
  reg  [31:0] rl;
  initial forever #2.5 clk_in = ~clk_in;
  gte_timer u_gte_timer (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wd), .wb_dat_out(rdat),
    .wb_ack_out(ack), .src_clk_in(src), .event_in(ev), .irq_vec_out(ivec), .irq_out(irq));
  task close_out;
    begin
      if (error_cnt == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task wb(input w, input [5:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_in);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      n = 0;
      @(posedge clk_in);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge clk_in);
        n = n + 1;
      end
      if (n == 20) begin
        error_cnt = error_cnt + 1;
        close_out;
      end else begin
        rd = rdat;
        cyc <= 1'b0;
      end
    end
  endtask
  task rc(input [5:0] a, input [31:0] e);
    begin
      wb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  // Slow source edges so each one survives the synchroniser
  task tick(input integer k);
    repeat (k) begin
      src <= 1'b1;
      repeat (4) @(posedge clk_in);
      src <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
  endtask
  initial begin
    code = $urandom(92) % 18;
    rl = 32'h2 + ($urandom % 4);
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rc(6'h08, 32'h0);
    rc(6'h20, 32'h0);
    wb(1'b1, 6'h24, 32'hffffffff);
    rc(6'h24, 32'h0);
    wb(1'b1, 6'h00, rl);
    wb(1'b1, 6'h08, 32'hc0 | (code << 12));
    rc(6'h04, rl);
    tick(1);
    rc(6'h04, rl - 1);
    tick(rl - 1);
    chk({12'h0, ivec}, 32'h0);
    tick(1);
    chk({12'h0, ivec}, 32'h1 << (code + 2));
    rc(6'h04, rl);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 6'h18, 32'h1);
    rc(6'h1c, code + 2);
    chk({31'h0, irq}, 32'h1);
    rc(6'h14, 32'h1);
    wb(1'b1, 6'h0c, $urandom);
    rc(6'h14, 32'h0);
    chk({12'h0, ivec}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 6'h00, 32'hfffffffe);
    wb(1'b1, 6'h08, 32'h180);
    tick(2);
    rc(6'h04, 32'h0);
    chk({12'h0, ivec}, 32'h4);
    wb(1'b1, 6'h00, 32'h0);
    wb(1'b1, 6'h08, 32'h80);
    tick(1);
    rc(6'h04, 32'hffffffff);
    wb(1'b1, 6'h00, 32'h003b3b7f);
    // Time format runs on the 32 kHz source divided by 256
    wb(1'b1, 6'h08, 32'h1b8);
    rc(6'h00, 32'h003b3b7f);
    tick(256);
    rc(6'h04, 32'h01000000);
    // Disabled counter holds, so the capture is predictable
    wb(1'b1, 6'h08, 32'h20000 | (code << 12));
    ev <= 18'h1 << code;
    repeat (6) @(posedge clk_in);
    ev <= 18'h0;
    rc(6'h10, 32'h003b3b7f);
    rc(6'h14, 32'h3);
    close_out;
  end
endmodule
